// ==== rtl/tca_pkg.sv ====
// Package with register map, field layout, carriers and states of the averager.
package tca_pkg;
  // Register indices; the Wishbone byte address is four times the index.
  localparam logic [15:0] IDX_CTRL = 16'hffa0;
  localparam logic [15:0] IDX_AVN = 16'hffa1;
  localparam logic [15:0] IDX_NOISE = 16'hffa2;
  localparam logic [15:0] IDX_STAT = 16'hffa3;
  localparam logic [15:0] IDX_SPD_LO = 16'hffa4;
  localparam logic [15:0] IDX_SPD_HI = 16'hffa5;
  localparam logic [15:0] IDX_X_LO = 16'hffa8;
  localparam logic [15:0] IDX_X_HI = 16'hffa9;
  localparam logic [15:0] IDX_Y_LO = 16'hffaa;
  localparam logic [15:0] IDX_Y_HI = 16'hffab;
  // Field positions.
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_CONST_BIT = 4;
  localparam int unsigned STAT_FLAG_BIT = 0;
  // Reset values.
  localparam logic [3:0] NOISE_RESET = 4'h8;
  localparam logic [2:0] AVN_RESET = 3'h0;
  localparam logic [7:0] SPD_RESET = 8'h00;
  // Shift amounts: samples per axis are two to the power of the shift.
  localparam logic [3:0] SHIFT_X16 = 4'h8;
  localparam logic [3:0] SHIFT_X8 = 4'h7;
  localparam logic [3:0] SHIFT_X4 = 4'h6;
  localparam logic [3:0] SHIFT_X2 = 4'h5;
  localparam logic [3:0] SHIFT_X1 = 4'h4;

  typedef enum logic [1:0] {ST_IDLE, ST_X, ST_Y} tca_phase_type;

  // Request towards the converter and the sample it returns.
  typedef struct packed {
    logic req;
    logic axis;
  } tca_adc_req_type;

  typedef struct packed {
    logic valid;
    logic [11:0] data;
  } tca_adc_res_type;

  // Whole state of the averager.
  typedef struct packed {
    tca_phase_type phase;
    logic ack;
    logic [7:0] rdat;
    logic run;
    logic const_mode;
    logic [2:0] average_count_select;
    logic [3:0] noise_sel;
    logic [7:0] spd_lo;
    logic [7:0] spd_hi;
    logic [11:0] x_val;
    logic [11:0] y_val;
    logic flag;
    logic [3:0] shift;
    logic [3:0] next_shift;
    logic [8:0] cnt;
    logic [19:0] sum;
    logic [11:0] vmax;
    logic [11:0] vmin;
    logic [11:0] x_mean;
    logic x_ok;
    logic [11:0] prev_x;
    logic [11:0] prev_y;
    tca_adc_req_type adc;
  } tca_state_type;
endpackage : tca_pkg

// ==== rtl/tca_averager.sv ====
// Touch coordinate averager with a classic Wishbone register slave.
// Notes on behaviour
// [R1] Average 16 to 256 samples per axis.
// [R2] X result twelve bits, low byte then nibble.
// [R3] Y result twelve bits, low byte then nibble.
// [R4] Flag raised when both X and Y written.
// [R5] Constant bit one selects fixed count.
// [R6] Count selector maps to sixteen times 16..1.
// [R7] Same count for X and Y.
// [R8] Constant bit zero is normal; resets zero.
// [R9] Speed is sum of absolute coordinate differences.
// [R10] Four thresholds choose next detection count.
// [R11] Slower pen gives more conversions.
// [R12] Speed threshold code n means 2(n+1).
// [R13] Software keeps thresholds in descending order.
// [R14] Track maximum and minimum per axis.
// [R15] Spread above noise threshold skips update.
// [R16] Noise threshold code n means 4(n+1).
// [R17] Noise threshold resets to code eight.
// [R18] Software tunes noise threshold for its needs.
// [R19] Update flag set after result registers written.
// [R20] Run bit repeats detection, zero stops it.
// [R21] Speed above thresholds picks 16x1 to 16x16.
// [R22] Results read-only, upper nibble reads zero.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tca_averager (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Converter side.
  output tca_pkg::tca_adc_req_type adc_req,
  input wire tca_pkg::tca_adc_res_type adc_res,
  // Data update flag as a level.
  output logic data_update_flag
);

  tca_pkg::tca_state_type s_r;
  tca_pkg::tca_state_type s_nxt;

  // Next state: bus slave, registers and the sampling sequence.
  always_comb begin
    logic acc;
    logic wr;
    logic [15:0] idx;
    logic [19:0] sum_new;
    logic [11:0] max_new;
    logic [11:0] min_new;
    logic [11:0] mean;
    logic [11:0] spread;
    logic [6:0] noise_thr;
    logic noisy;
    logic last;
    logic [12:0] speed;
    logic [12:0] dx;
    logic [12:0] dy;
    logic [3:0] sel_shift;
    logic [3:0] fixed_shift;
    acc = 1'b0;
    wr = 1'b0;
    idx = 16'h0000;
    sum_new = 20'h00000;
    max_new = 12'h000;
    min_new = 12'h000;
    mean = 12'h000;
    spread = 12'h000;
    noise_thr = 7'h00;
    noisy = 1'b0;
    last = 1'b0;
    speed = 13'h0000;
    dx = 13'h0000;
    dy = 13'h0000;
    sel_shift = tca_pkg::SHIFT_X16;
    fixed_shift = tca_pkg::SHIFT_X16;
    s_nxt = s_r;

    // One wait state: ack follows the request by one cycle.
    acc = wb_cyc_i & wb_stb_i & ~s_r.ack;
    wr = acc & wb_we_i & wb_sel_i[0];
    idx = wb_adr_i[17:2];
    s_nxt.ack = acc;

    // Read mux; unmapped indices read as zero.
    s_nxt.rdat = 8'h00;
    unique case (idx)
      tca_pkg::IDX_CTRL: begin
        s_nxt.rdat[tca_pkg::CTRL_RUN_BIT] = s_r.run;
        s_nxt.rdat[tca_pkg::CTRL_CONST_BIT] = s_r.const_mode;
      end
      tca_pkg::IDX_AVN: s_nxt.rdat = {5'h00, s_r.average_count_select};
      tca_pkg::IDX_NOISE: s_nxt.rdat = {4'h0, s_r.noise_sel};
      tca_pkg::IDX_STAT: s_nxt.rdat[tca_pkg::STAT_FLAG_BIT] = s_r.flag;
      tca_pkg::IDX_SPD_LO: s_nxt.rdat = s_r.spd_lo;
      tca_pkg::IDX_SPD_HI: s_nxt.rdat = s_r.spd_hi;
      tca_pkg::IDX_X_LO: s_nxt.rdat = s_r.x_val[7:0]; // R2
      tca_pkg::IDX_X_HI: s_nxt.rdat = {4'h0, s_r.x_val[11:8]}; // R22
      tca_pkg::IDX_Y_LO: s_nxt.rdat = s_r.y_val[7:0]; // R3
      tca_pkg::IDX_Y_HI: s_nxt.rdat = {4'h0, s_r.y_val[11:8]}; // R22
      default: s_nxt.rdat = 8'h00;
    endcase

    // Register writes; result registers take no writes.
    if (wr) begin
      unique case (idx)
        tca_pkg::IDX_CTRL: begin
          s_nxt.run = wb_dat_i[tca_pkg::CTRL_RUN_BIT]; // R20
          s_nxt.const_mode = wb_dat_i[tca_pkg::CTRL_CONST_BIT]; // R5 R8
        end
        tca_pkg::IDX_AVN: s_nxt.average_count_select = wb_dat_i[2:0];
        tca_pkg::IDX_NOISE: s_nxt.noise_sel = wb_dat_i[3:0];
        tca_pkg::IDX_STAT: begin
          if (wb_dat_i[tca_pkg::STAT_FLAG_BIT]) begin
            s_nxt.flag = 1'b0;
          end
        end
        tca_pkg::IDX_SPD_LO: s_nxt.spd_lo = wb_dat_i[7:0];
        tca_pkg::IDX_SPD_HI: s_nxt.spd_hi = wb_dat_i[7:0];
        default: s_nxt.run = s_nxt.run;
      endcase
    end

    // Fixed count from the selector; top bit set means 16x1.
    if (s_r.average_count_select[2]) begin
      fixed_shift = tca_pkg::SHIFT_X1; // R6
    end else begin
      unique case (s_r.average_count_select[1:0])
        2'h0: fixed_shift = tca_pkg::SHIFT_X16; // R6
        2'h1: fixed_shift = tca_pkg::SHIFT_X8;
        2'h2: fixed_shift = tca_pkg::SHIFT_X4;
        2'h3: fixed_shift = tca_pkg::SHIFT_X2;
      endcase
    end

    // Sample accumulation shared by both axes.
    sum_new = s_r.sum + {8'h00, adc_res.data};
    if (s_r.cnt == 9'h000) begin
      max_new = adc_res.data;
      min_new = adc_res.data;
    end else begin
      max_new = (adc_res.data > s_r.vmax) ? adc_res.data : s_r.vmax; // R14
      min_new = (adc_res.data < s_r.vmin) ? adc_res.data : s_r.vmin; // R14
    end
    mean = 12'(sum_new >> s_r.shift); // R1
    spread = max_new - min_new; // R14
    noise_thr = {1'b0, s_r.noise_sel, 2'b00} + 7'h04; // R16
    noisy = {1'b0, spread} > {6'h00, noise_thr}; // R15
    last = (s_r.cnt + 9'h001) == (9'h001 << s_r.shift); // R1 R7

    // Speed and next count from the four thresholds.
    dx = (s_r.prev_x > s_r.x_mean) ? 13'(s_r.prev_x - s_r.x_mean)
                                   : 13'(s_r.x_mean - s_r.prev_x);
    dy = (s_r.prev_y > mean) ? 13'(s_r.prev_y - mean)
                             : 13'(mean - s_r.prev_y);
    speed = dx + dy; // R9
    if (speed > {7'h00, s_r.spd_hi[7:4], 1'b0} + 13'h0002) begin // R12
      sel_shift = tca_pkg::SHIFT_X1; // R21
    end else if (speed > {7'h00, s_r.spd_hi[3:0], 1'b0} + 13'h0002) begin
      sel_shift = tca_pkg::SHIFT_X2; // R21
    end else if (speed > {7'h00, s_r.spd_lo[7:4], 1'b0} + 13'h0002) begin
      sel_shift = tca_pkg::SHIFT_X4; // R21
    end else if (speed > {7'h00, s_r.spd_lo[3:0], 1'b0} + 13'h0002) begin
      sel_shift = tca_pkg::SHIFT_X8; // R21 R11
    end else begin
      sel_shift = tca_pkg::SHIFT_X16; // R11
    end

    // Detection sequence.
    unique case (s_r.phase)
      tca_pkg::ST_IDLE: begin
        if (s_r.run) begin
          s_nxt.shift = s_r.const_mode ? fixed_shift : s_r.next_shift;
          s_nxt.phase = tca_pkg::ST_X;
          s_nxt.adc.req = 1'b1;
          s_nxt.adc.axis = 1'b0;
        end
      end
      tca_pkg::ST_X: begin
        if (!s_r.run) begin
          s_nxt.phase = tca_pkg::ST_IDLE; // R20
          s_nxt.adc.req = 1'b0;
          s_nxt.cnt = 9'h000;
          s_nxt.sum = 20'h00000;
        end else if (adc_res.valid) begin
          s_nxt.sum = sum_new;
          s_nxt.vmax = max_new;
          s_nxt.vmin = min_new;
          s_nxt.cnt = s_r.cnt + 9'h001;
          if (last) begin
            s_nxt.x_mean = mean;
            s_nxt.x_ok = ~noisy; // R15
            s_nxt.cnt = 9'h000;
            s_nxt.sum = 20'h00000;
            s_nxt.phase = tca_pkg::ST_Y;
            s_nxt.adc.axis = 1'b1; // R7
          end
        end
      end
      tca_pkg::ST_Y: begin
        if (!s_r.run) begin
          s_nxt.phase = tca_pkg::ST_IDLE; // R20
          s_nxt.adc.req = 1'b0;
          s_nxt.cnt = 9'h000;
          s_nxt.sum = 20'h00000;
        end else if (adc_res.valid) begin
          s_nxt.sum = sum_new;
          s_nxt.vmax = max_new;
          s_nxt.vmin = min_new;
          s_nxt.cnt = s_r.cnt + 9'h001;
          if (last) begin
            if (s_r.x_ok) begin
              s_nxt.x_val = s_r.x_mean; // R15 R2
            end
            if (!noisy) begin
              s_nxt.y_val = mean; // R15 R3
            end
            if (s_r.x_ok && !noisy) begin
              s_nxt.flag = 1'b1; // R4 R19
            end
            s_nxt.prev_x = s_r.x_mean;
            s_nxt.prev_y = mean;
            s_nxt.next_shift = sel_shift; // R10
            s_nxt.shift = s_r.const_mode ? fixed_shift : sel_shift; // R5
            s_nxt.cnt = 9'h000;
            s_nxt.sum = 20'h00000;
            s_nxt.phase = tca_pkg::ST_X; // R20
            s_nxt.adc.axis = 1'b0;
          end
        end
      end
      // The fourth phase code is unused; fall back to idle with no request.
      default: begin
        s_nxt.phase = tca_pkg::ST_IDLE;
        s_nxt.adc.req = 1'b0;
        s_nxt.cnt = 9'h000;
        s_nxt.sum = 20'h00000;
      end
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.phase <= tca_pkg::ST_IDLE;
      s_r.const_mode <= 1'b0; // R8
      s_r.average_count_select <= tca_pkg::AVN_RESET;
      s_r.noise_sel <= tca_pkg::NOISE_RESET; // R17
      s_r.spd_lo <= tca_pkg::SPD_RESET;
      s_r.spd_hi <= tca_pkg::SPD_RESET;
      s_r.shift <= tca_pkg::SHIFT_X16;
      s_r.next_shift <= tca_pkg::SHIFT_X16;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register.
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = {24'h000000, s_r.rdat};
  assign adc_req = s_r.adc;
  assign data_update_flag = s_r.flag;

endmodule : tca_averager
`default_nettype wire

// ==== tb/tca_averager_sva.sv ====
// Checker of bus, converter and flag timing at the averager ports.
`timescale 1ns/1ps
`default_nettype none
module tca_averager_sva (
  // Clock, reset and bus.
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Converter and flag.
  input wire tca_pkg::tca_adc_req_type adc_req,
  input wire tca_pkg::tca_adc_res_type adc_res,
  input wire logic data_update_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // A request that the slave has not yet answered.
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Properties over bus, converter axis and flag.
  property p_ack; s_take |=> wb_ack_o; endproperty
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  property p_wide; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
  property p_nib;
    wb_ack_o && $past(!wb_we_i && wb_adr_i[17:4] == 14'h3fea && wb_adr_i[2])
      |-> wb_dat_o[7:4] == 4'h0;
  endproperty
  property p_rst;
    disable iff (1'b0)
    !reset_n |=> !wb_ack_o && !adc_req.req && !data_update_flag;
  endproperty
  property p_axis;
    $rose(adc_req.axis) |-> $past(adc_res.valid && adc_req.req);
  endproperty
  property p_flag;
    $rose(data_update_flag) |-> $past(adc_req.axis && adc_res.valid);
  endproperty
  property p_clr;
    $fell(data_update_flag) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i);
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  a_pulse: assert property (p_pulse) else $error("ack too long");
  a_cause: assert property (p_cause) else $error("ack unasked");
  a_wide: assert property (p_wide) else $error("upper data set");
  a_nib: assert property (p_nib) else $error("nibble set");
  a_rst: assert property (p_rst) else $error("reset outputs");
  a_axis: assert property (p_axis) else $error("axis early");
  a_flag: assert property (p_flag) else $error("flag early");
  a_clr: assert property (p_clr) else $error("flag lost");
endmodule : tca_averager_sva
bind tca_averager tca_averager_sva i_tca_averager_sva (.mclk, .reset_n,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .adc_req, .adc_res, .data_update_flag);
`default_nettype wire

// ==== tb/tca_adc_model.sv ====
// Converter model offering one sample every fourth cycle while requested.
`timescale 1ns/1ps
`default_nettype none
module tca_adc_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Design side.
  input wire tca_pkg::tca_adc_req_type req,
  output tca_pkg::tca_adc_res_type res,
  // Sample pattern: base per axis and spread.
  input wire logic [11:0] bx,
  input wire logic [11:0] by,
  input wire logic [11:0] sp
);
  logic [1:0] ph_r;
  logic hi_r;
  logic [11:0] v;
  // Sample pacing, and alternation between base and base plus spread.
  always_ff @(posedge mclk) begin
    if (!reset_n || !req.req) ph_r <= 2'h0;
    else ph_r <= ph_r + 2'h1;
    if (!reset_n) hi_r <= 1'b0;
    else if (res.valid) hi_r <= !hi_r;
  end
  // Data lines carry the inverse between samples.
  assign v = (req.axis ? by : bx) + (hi_r ? sp : 12'h000);
  assign res.valid = req.req && ph_r == 2'h3;
  assign res.data = res.valid ? v : ~v;
endmodule : tca_adc_model
`default_nettype wire

// ==== tb/tca_averager_tb.sv ====
// Self-checking bench of the touch coordinate averager.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module tca_averager_tb;
  typedef struct packed {
    logic [2:0] average_count_select;
    logic [3:0] noise_threshold;
    logic [11:0] bx, by, sp;
    logic [8:0] n;
    logic upd;
    logic [11:0] x, y;
  } tca_row_type;
  tca_row_type rows [5];
  logic [11:0] ox [9] = '{0, 0, 0, 5, 15, 20, 20, 19, 19};
  logic [11:0] oy [9] = '{0, 0, 0, 4, 11, 11, 8, 8, 8};
  logic [8:0] ne [9] = '{0, 0, 0, 256, 32, 16, 64, 128, 256};
  logic mclk, reset_n, cyc, stb, we, ack, flag, pa;
  logic [17:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dat_o;
  logic [11:0] bx, by, sp;
  logic [8:0] cx, cy, lx, ly;
  logic [7:0] q;
  tca_pkg::tca_adc_req_type req;
  tca_pkg::tca_adc_res_type res;
  int ndet, n_errors, samples_checked;
  tca_averager i_tca_averager (.mclk(mclk), .reset_n(reset_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .adc_req(req), .adc_res(res), .data_update_flag(flag));
  tca_adc_model i_tca_adc_model (.mclk(mclk), .reset_n(reset_n),
    .req(req), .res(res), .bx(bx), .by(by), .sp(sp));
  // Counts samples per axis and closes a record at each detection end.
  always @(posedge mclk) begin
    pa <= req.axis;
    if (!reset_n) begin
      ndet <= 0;
      cx <= 9'h000;
      cy <= 9'h000;
    end else if (pa && !req.axis) begin
      ndet <= ndet + 1;
      lx <= cx;
      ly <= cy;
      cx <= 9'h000;
      cy <= 9'h000;
    end else if (res.valid && req.req) begin
      if (req.axis) cy <= cy + 9'h001;
      else cx <= cx + 9'h001;
    end
  end
  // One Wishbone cycle; read data lands in q.
  task automatic bus(input logic w, input logic [15:0] i,
                     input logic [7:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {24'h000000, d};
    do @(posedge mclk); while (ack !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic wait_det();
    int s;
    s = ndet;
    while (ndet == s) @(posedge mclk);
  endtask : wait_det
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  // Clock and watchdog.
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #300000;
    n_errors++;
    conclude();
  end
  // Main sequence: reset values, count table, normal mode, reset again.
  initial begin
    rows[0] = '{3'h0, 4'h8, 12'h064, 12'h0c8, 12'h008, 256, 1'b1, 12'h068, 12'h0cc};
    rows[1] = '{3'h1, 4'h8, 12'habc, 12'h123, 12'h024, 128, 1'b1, 12'hace, 12'h135};
    rows[2] = '{3'h2, 4'h8, 12'h000, 12'h000, 12'h026, 64, 1'b0, 12'hace, 12'h135};
    rows[3] = '{3'h3, 4'hf, 12'hf00, 12'h010, 12'h040, 32, 1'b1, 12'hf20, 12'h030};
    rows[4] = '{3'h5, 4'h0, 12'h555, 12'haaa, 12'h004, 16, 1'b1, 12'h557, 12'haac};
    n_errors = 0;
    samples_checked = 0;
    {reset_n, cyc, stb, we, adr, dat, bx, by, sp} = '0;
    sel = 4'h1;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    bus(1'b0, tca_pkg::IDX_NOISE, 8'h00);
    `CHK("noise reset", 8'h08, q)
    bus(1'b0, tca_pkg::IDX_CTRL, 8'h00);
    `CHK("ctrl reset", 8'h00, q)
    foreach (rows[r]) begin
      bx <= rows[r].bx;
      by <= rows[r].by;
      sp <= rows[r].sp;
      bus(1'b1, tca_pkg::IDX_AVN, {5'h00, rows[r].average_count_select});
      bus(1'b1, tca_pkg::IDX_NOISE, {4'h0, rows[r].noise_threshold});
      bus(1'b1, tca_pkg::IDX_CTRL, 8'h11);
      wait_det();
      bus(1'b1, tca_pkg::IDX_STAT, 8'h01);
      wait_det();
      `CHK("x count", rows[r].n, lx)
      `CHK("y count", rows[r].n, ly)
      `CHK("flag", rows[r].upd, flag)
      for (int k = 0; k < 4; k++) begin
        bus(1'b0, tca_pkg::IDX_X_LO + k[15:0], 8'h00);
        `CHK("result", 8'({4'h0, (k[1] ? rows[r].y : rows[r].x)} >> {k[0], 3'h0}), q)
      end
    end
    bus(1'b1, tca_pkg::IDX_X_LO, 8'hff);
    bus(1'b0, tca_pkg::IDX_X_LO, 8'h00);
    `CHK("read only", 8'h57, q)
    bus(1'b0, 16'hffa6, 8'h00);
    `CHK("unmapped", 8'h00, q)
    bus(1'b1, tca_pkg::IDX_CTRL, 8'h00);
    `CHK("stopped", 1'b0, req.req)
    bus(1'b1, tca_pkg::IDX_SPD_HI, 8'h73);
    bus(1'b1, tca_pkg::IDX_SPD_LO, 8'h10);
    bx <= 12'h400;
    by <= 12'h400;
    sp <= 12'h002;
    bus(1'b1, tca_pkg::IDX_CTRL, 8'h01);
    for (int k = 1; k < 9; k++) begin
      wait_det();
      if (k > 2) `CHK("speed count", ne[k], lx)
      if (k < 8) begin
        bx <= 12'h400 + ox[k + 1];
        by <= 12'h400 + oy[k + 1];
      end
    end
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    bus(1'b0, tca_pkg::IDX_NOISE, 8'h00);
    `CHK("noise again", 8'h08, q)
    conclude();
  end
endmodule : tca_averager_tb
`default_nettype wire
